// ### design/rtes_defines.svh
// shared constants for the two-wire slave sequencer of the clock/memory device
`ifndef RTES_DEFINES_SVH
`define RTES_DEFINES_SVH

// ==========================================================
// slave address patterns (upper seven bits)
`define RTES_ADDR_ARRAY 7'h57
`define RTES_ADDR_CTRL 7'h6f

// ==========================================================
// geometry and reset values
`define RTES_ADDR_W 16
`define RTES_ADDR_RST 16'h0000
`define RTES_PAGE_BITS 4

// ==========================================================
// timing
`define RTES_CLK_HZ 10000000
`define RTES_WRITE_MS 12
`define RTES_WRITE_CYC ((`RTES_CLK_HZ / 1000) * `RTES_WRITE_MS)

`endif

// ### design/rtes_pkg.sv
// types for the two-wire slave sequencer
package rtes_pkg;
    typedef enum logic [2:0] {
        RTES_IDLE,
        RTES_DEV,
        RTES_ADDR_HI,
        RTES_ADDR_LO,
        RTES_WDATA,
        RTES_RDATA,
        RTES_RACK
    } rtes_state_type;
endpackage

// ### design/rtes_slave.sv
// two-wire slave sequencer: addressing, write commit, busy polling, reads
`timescale 1ns/1ps
`include "rtes_defines.svh"

// Behaviour
// - early stop resets, no write performed
// - valid write stop starts nonvolatile cycle
// - array address gets no ack while busy
// - counter holds last read address plus one
// - counter clears to zero at reset
// - read address acked, eight bits shifted out
// - word address bytes acked, then data returned
// - stop after word address loads counter
// - after stop, ignore bus until start
// - master ack after data gives next byte
// - read increment crosses page boundaries
// - counter wraps at end of space
// - busy cycle ignores bus, data released
// - ack only matching seven-bit slave address
// - write increments wrap within the page
module rtes_slave #(
    parameter int ADDR_W = `RTES_ADDR_W,
    parameter int WRITE_CYC = `RTES_WRITE_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] mem_wdata,
    output logic mem_wr,
    output logic ctrl_space,
    output logic nv_commit,
    output logic nv_busy
);
    // refuse widths the two word bytes cannot fill and counts the timer cannot hold
    if (ADDR_W < 9 || ADDR_W > 16 || WRITE_CYC < 1 || WRITE_CYC > 16777215) begin : g_bad_params
        $error("rtes_slave: unsupported parameters");
    end

    // ==========================================================
    // pin synchronisers and edge detection
    logic [1:0] scl_s_r, sda_s_r;
    logic scl_d_r, sda_d_r;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], scl_in};
            sda_s_r <= {sda_s_r[0], sda_in};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end
    wire scl = scl_s_r[1];
    wire sda = sda_s_r[1];
    wire scl_rise = scl && !scl_d_r;
    wire scl_fall = !scl && scl_d_r;
    wire start_ev = scl && scl_d_r && !sda && sda_d_r;
    wire stop_ev = scl && scl_d_r && sda && !sda_d_r;

    // ==========================================================
    // sequencer state
    rtes_pkg::rtes_state_type state_r;
    logic [3:0] bit_r;
    logic [7:0] shift_r;
    logic ack_phase_r;
    logic ack_drive_r;
    logic is_ctrl_r;
    logic wrote_r;
    logic [ADDR_W-1:0] addr_r;
    logic [23:0] busy_cnt_r;

    wire busy = busy_cnt_r != 24'h000000;
    wire [6:0] dev_id = shift_r[7:1];
    wire id_array = dev_id == `RTES_ADDR_ARRAY;
    wire id_ctrl = dev_id == `RTES_ADDR_CTRL;
    wire [ADDR_W-1:0] addr_inc = addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
    wire [`RTES_PAGE_BITS-1:0] col_inc = addr_r[`RTES_PAGE_BITS-1:0] + 4'h1;

    // ==========================================================
    // nonvolatile write timer
    // the clock rise just before a stop counts as one bit, so a byte boundary shows one
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            busy_cnt_r <= 24'h000000;
        end else if (stop_ev && state_r == rtes_pkg::RTES_WDATA && wrote_r && bit_r == 4'h1 && !ack_phase_r) begin
            busy_cnt_r <= 24'(WRITE_CYC);
        end else if (busy) begin
            busy_cnt_r <= busy_cnt_r - 24'h000001;
        end
    end

    // ==========================================================
    // byte engine and protocol state
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_r <= rtes_pkg::RTES_IDLE;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            ack_phase_r <= 1'b0;
            ack_drive_r <= 1'b0;
            is_ctrl_r <= 1'b0;
            wrote_r <= 1'b0;
            addr_r <= '0;
            mem_wdata <= 8'h00;
            mem_wr <= 1'b0;
        end else begin
            mem_wr <= 1'b0;
            // bump the column only after the strobe, so the byte lands at the
            // address it was meant for
            if (mem_wr) begin
                addr_r[`RTES_PAGE_BITS-1:0] <= col_inc;
            end
            if (busy) begin
                state_r <= rtes_pkg::RTES_IDLE;
                ack_drive_r <= 1'b0;
            end else if (start_ev) begin
                state_r <= rtes_pkg::RTES_DEV;
                bit_r <= 4'h0;
                ack_phase_r <= 1'b0;
                ack_drive_r <= 1'b0;
                wrote_r <= 1'b0;
            end else if (stop_ev) begin
                // a stop mid-byte or before a data byte leaves memory alone; a stop
                // after word bytes has already loaded the counter
                state_r <= rtes_pkg::RTES_IDLE;
                ack_drive_r <= 1'b0;
            end else if (state_r != rtes_pkg::RTES_IDLE) begin
                if (scl_rise && !ack_phase_r) begin
                    // while sending, the bit on the line must hold until the clock falls
                    if (state_r != rtes_pkg::RTES_RDATA) begin
                        shift_r <= {shift_r[6:0], sda};
                    end
                    bit_r <= bit_r + 4'h1;
                end else if (scl_rise && ack_phase_r && state_r == rtes_pkg::RTES_RACK) begin
                    // master ack continues, nack goes idle until the next start
                    if (!sda) begin
                        state_r <= rtes_pkg::RTES_RDATA;
                    end else begin
                        state_r <= rtes_pkg::RTES_IDLE;
                    end
                end else if (scl_fall && !ack_phase_r && bit_r == 4'h8) begin
                    bit_r <= 4'h0;
                    ack_phase_r <= 1'b1;
                    case (state_r)
                        rtes_pkg::RTES_DEV: begin
                            if (id_array || id_ctrl) begin
                                ack_drive_r <= 1'b1;
                                is_ctrl_r <= id_ctrl;
                                state_r <= shift_r[0] ? rtes_pkg::RTES_RDATA : rtes_pkg::RTES_ADDR_HI;
                            end else begin
                                state_r <= rtes_pkg::RTES_IDLE;
                            end
                        end
                        rtes_pkg::RTES_ADDR_HI: begin
                            ack_drive_r <= 1'b1;
                            addr_r[ADDR_W-1:8] <= shift_r[ADDR_W-9:0];
                            state_r <= rtes_pkg::RTES_ADDR_LO;
                        end
                        rtes_pkg::RTES_ADDR_LO: begin
                            ack_drive_r <= 1'b1;
                            addr_r[7:0] <= shift_r;
                            state_r <= rtes_pkg::RTES_WDATA;
                        end
                        rtes_pkg::RTES_WDATA: begin
                            ack_drive_r <= 1'b1;
                            mem_wdata <= shift_r;
                            mem_wr <= 1'b1;
                            wrote_r <= 1'b1;
                        end
                        rtes_pkg::RTES_RDATA: begin
                            // sent the byte, release line for master ack
                            ack_drive_r <= 1'b0;
                            addr_r <= addr_inc;
                            state_r <= rtes_pkg::RTES_RACK;
                        end
                        default: begin
                            state_r <= rtes_pkg::RTES_IDLE;
                        end
                    endcase
                end else if (scl_fall && ack_phase_r) begin
                    ack_phase_r <= 1'b0;
                    ack_drive_r <= 1'b0;
                    if (state_r == rtes_pkg::RTES_RDATA) begin
                        shift_r <= mem_rdata;
                    end
                end else if (scl_fall && state_r == rtes_pkg::RTES_RDATA && bit_r != 4'h0) begin
                    shift_r <= {shift_r[6:0], 1'b1};
                end
            end
        end
    end

    // ==========================================================
    // ack and read data drive on data line
    logic drive_low;
    always_comb begin
        drive_low = 1'b0;
        if (!busy) begin
            if (ack_phase_r) begin
                drive_low = ack_drive_r;
            end else if (state_r == rtes_pkg::RTES_RDATA) begin
                drive_low = !shift_r[7];
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = !drive_low;
    assign mem_addr = addr_r;
    assign ctrl_space = is_ctrl_r;
    assign nv_commit = busy_cnt_r == 24'(WRITE_CYC);
    assign nv_busy = busy;
endmodule

// ### testbench/rtes_slave_monitor.sv
// assertion checker for the two-wire slave sequencer
`timescale 1ns/1ps
module rtes_slave_monitor #(
    parameter int ADDR_W = 16,
    parameter int WRITE_CYC = 120000
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic ctrl_space,
    input wire logic nv_commit,
    input wire logic nv_busy
);
    // ==========================================
    // properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    int busy_cnt_r;
    always_ff @(posedge ref_clk) begin
        busy_cnt_r <= (!resetn || !nv_busy) ? 0 : busy_cnt_r + 1;
    end
    property p_rst_addr; $rose(resetn) |-> mem_addr == '0; endproperty
    a_rst_addr: assert property (p_rst_addr) else $error("counter not zero");
    property p_busy_len; $fell(nv_busy) |-> busy_cnt_r == WRITE_CYC; endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length");
    property p_commit; nv_commit |-> nv_busy ##1 !nv_commit; endproperty
    a_commit: assert property (p_commit) else $error("commit pulse");
    property p_busy_quiet; nv_busy |-> sda_oe_n; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
    property p_busy_nowr; nv_busy |-> !mem_wr; endproperty
    a_busy_nowr: assert property (p_busy_nowr) else $error("write while busy");
    property p_busy_hold; nv_busy && $past(nv_busy) |-> $stable(mem_addr); endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("address moved while busy");
    property p_oe_low; $changed(sda_oe_n) |-> !scl_in; endproperty
    a_oe_low: assert property (p_oe_low) else $error("data moved with clock high");
    property p_wr_pulse; mem_wr |=> !mem_wr; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    property p_wr_page;
        mem_wr |=> (mem_addr[ADDR_W-1:4] == $past(mem_addr[ADDR_W-1:4]))
            && (mem_addr[3:0] == $past(mem_addr[3:0]) + 4'h1);
    endproperty
    a_wr_page: assert property (p_wr_page) else $error("write address step");
    property p_open_drain; sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data drives high");
endmodule
bind rtes_slave rtes_slave_monitor #(.ADDR_W(ADDR_W), .WRITE_CYC(WRITE_CYC)) u_mon (.ref_clk(ref_clk),
    .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
    .ctrl_space(ctrl_space), .nv_commit(nv_commit), .nv_busy(nv_busy));

// ### testbench/rtes_master_model.sv
// two-wire bus master model on the far side of the slave
`timescale 1ns/1ps
module rtes_master_model (
    input wire logic ref_clk,
    input wire logic sda_bus,
    output logic scl,
    output logic sda_m
);
    // ==========================================
    // bit and byte cycles, 800 ns bus clock
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // clock stands high between frames
    task automatic xbit(input logic b, output logic s);
        tick(2);
        sda_m <= b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        s = sda_bus;
        tick(2);
        scl <= 1'b0;
    endtask
    task automatic start();
        tick(2);
        sda_m <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(2);
        sda_m <= 1'b0;
        tick(2);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_m <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(2);
        sda_m <= 1'b1;
        tick(4);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xbit(b[i], s);
        xbit(1'b1, s);
        ack = !s;
    endtask
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(!mack, s);
    endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the two-wire slave sequencer
`timescale 1ns/1ps
module testbench;
    localparam int WC = 400;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic scl, sda_m, sda_out, sda_oe_n, mem_wr, ctrl_space, nv_commit, nv_busy, a;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata, d;
    wire logic sda_bus = sda_m & sda_oe_n;
    // pattern memory: each byte is the two address bytes xored with 3c, so addresses share bytes
    wire logic [7:0] mem_rdata = mem_addr[15:8] ^ mem_addr[7:0] ^ 8'h3c;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    always #50 ref_clk = ~ref_clk;
    rtes_slave #(.WRITE_CYC(WC)) dut (.ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_bus),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_wdata(mem_wdata), .mem_wr(mem_wr), .ctrl_space(ctrl_space), .nv_commit(nv_commit),
        .nv_busy(nv_busy));
    rtes_master_model m (.ref_clk(ref_clk), .sda_bus(sda_bus), .scl(scl), .sda_m(sda_m));
    // ==========================================
    // helpers and scenarios
    function automatic logic [7:0] pat(input logic [15:0] x);
        return x[15:8] ^ x[7:0] ^ 8'h3c;
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic hdr(input logic [15:0] w);
        m.start();
        m.wbyte(8'hae, a); chk("ack dev", 1, a);
        m.wbyte(w[15:8], a); chk("ack hi", 1, a);
        m.wbyte(w[7:0], a); chk("ack lo", 1, a);
    endtask
    task automatic rd2(input logic [15:0] e0, input logic [15:0] e1);
        m.start();
        m.wbyte(8'haf, a); chk("ack rd", 1, a);
        chk("array space", 0, ctrl_space);
        m.rbyte(1'b1, d); chk("byte0", pat(e0), d);
        m.rbyte(1'b0, d); chk("byte1", pat(e1), d);
        m.stop();
    endtask
    task automatic t_write_poll();
        hdr(16'h002f);
        m.wbyte(8'ha5, a); chk("ack data", 1, a);
        m.stop();
        chk("busy", 1, nv_busy);
        chk("wdata", 8'ha5, mem_wdata);
        chk("page wrap", 16'h0020, mem_addr);
        m.start();
        m.wbyte(8'hae, a); chk("poll busy", 0, a);
        m.stop();
        for (int i = 0; i < WC && nv_busy; i++) m.tick(1);
        chk("done", 0, nv_busy);
        m.start();
        m.wbyte(8'hae, a); chk("poll ready", 1, a);
        m.stop();
    endtask
    task automatic t_bad_frames();
        hdr(16'h0030);
        m.wbyte(8'h5a, a); chk("ack data2", 1, a);
        repeat (4) m.xbit(1'b1, a);
        m.stop();
        m.tick(10);
        chk("early stop", 0, nv_busy);
        m.start();
        m.wbyte(8'hdf, a); chk("ack ctrl", 1, a);
        chk("ctrl space", 1, ctrl_space);
        m.rbyte(1'b0, d); chk("ctrl byte", pat(16'h0031), d);
        m.stop();
        m.start();
        m.wbyte(8'ha0, a); chk("bad addr", 0, a);
        m.stop();
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        m.tick(5);
        rd2(16'h0000, 16'h0001);
        hdr(16'hffff);
        rd2(16'hffff, 16'h0000);
        hdr(16'h000f);
        m.stop();
        chk("no data stop", 0, nv_busy);
        rd2(16'h000f, 16'h0010);
        t_write_poll();
        t_bad_frames();
        conclude();
    end
endmodule
